// file: inc/qbsp_pkg.sv
package qbsp_pkg;

  // ----------------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------------
  localparam int unsigned QBSP_LANE_W      = 9;
  localparam int unsigned QBSP_LANES_WIDE  = 4;
  localparam int unsigned QBSP_LANES_NARROW = 2;
  localparam int unsigned QBSP_AW_WIDE     = 19;
  localparam int unsigned QBSP_AW_NARROW   = 20;
  localparam int unsigned QBSP_BEATS       = 4;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned QBSP_CLK_PERIOD_NS = 100;
  // One main strobe cycle is two core cycles; read latency is two of them
  localparam int unsigned QBSP_STROBE_PERIOD_NS = 2 * QBSP_CLK_PERIOD_NS;
  localparam int unsigned QBSP_RD_LAT_NS   = 2 * QBSP_STROBE_PERIOD_NS;
  localparam int unsigned QBSP_RD_LAT_CYC  =
    (QBSP_RD_LAT_NS + QBSP_CLK_PERIOD_NS - 1) / QBSP_CLK_PERIOD_NS;
  // Fetch, load and launch take three of the latency cycles
  localparam logic [1:0]  QBSP_RD_WAIT_INIT = 2'(QBSP_RD_LAT_CYC - 3);
  localparam logic [2:0]  QBSP_BURST_LEN   = 3'h4;
  localparam logic [1:0]  QBSP_LAST_BEAT   = 2'h3;

  // ----------------------------------------------------------------------
  // Buffering
  // ----------------------------------------------------------------------
  localparam int unsigned QBSP_FIFO_DEPTH  = 8;

  // ----------------------------------------------------------------------
  // Write port state
  // ----------------------------------------------------------------------
  typedef enum logic {
    QBSP_WR_IDLE  = 1'b0,
    QBSP_WR_BURST = 1'b1
  } qbsp_wr_e;

endpackage : qbsp_pkg

// file: logic/qbsp_fifo.sv
`timescale 1ns/1ns
module qbsp_fifo
  import qbsp_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = QBSP_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] slot;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [PW:0]                 cnt;
  } qbsp_fifo_s;

  qbsp_fifo_s s;
  qbsp_fifo_s n;
  logic       push;
  logic       pop;

  // Wrap explicitly so a depth that is not a power of two still works
  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    return (p == LAST_PTR) ? '0 : p + 1'b1;
  endfunction : next_ptr

  assign in_ready  = (s.cnt != FULL_CNT);
  assign out_valid = (s.cnt != '0);
  assign out_data  = s.slot[s.rp];

  always_comb begin
    n    = s;
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    if (push) begin
      n.slot[s.wp] = in_data;
      n.wp         = next_ptr(s.wp);
    end
    if (pop) begin
      n.rp = next_ptr(s.rp);
    end
    if (push && !pop) begin
      n.cnt = s.cnt + 1'b1;
    end else if (pop && !push) begin
      n.cnt = s.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

endmodule : qbsp_fifo

// file: logic/qbsp_mem.sv
`timescale 1ns/1ns
module qbsp_mem
  import qbsp_pkg::*;
#(
  parameter int unsigned LANES = QBSP_LANES_WIDE,
  parameter int unsigned AW    = QBSP_AW_WIDE,
  localparam int unsigned W    = QBSP_LANE_W * LANES
) (
  // Clock
  input  wire logic                              clk,
  // Line write, lane masked
  input  wire logic                              wr_en,
  input  wire logic [AW-1:0]                     wr_addr,
  input  wire logic [QBSP_BEATS-1:0][LANES-1:0]  wr_mask,
  input  wire logic [QBSP_BEATS-1:0][W-1:0]      wr_data,
  // Line read
  input  wire logic [AW-1:0]                     rd_addr,
  output logic [QBSP_BEATS-1:0][W-1:0]           rd_data
);

  // Four arrays, one per burst position, all sharing the burst address
  logic [W-1:0] bank_q [QBSP_BEATS][2**AW];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      for (int b = 0; b < QBSP_BEATS; b++) begin
        for (int l = 0; l < LANES; l++) begin
          if (wr_mask[b][l]) begin
            bank_q[b][wr_addr][l*QBSP_LANE_W +: QBSP_LANE_W] <=
              wr_data[b][l*QBSP_LANE_W +: QBSP_LANE_W];
          end
        end
      end
    end
  end

  always_comb begin
    for (int b = 0; b < QBSP_BEATS; b++) begin
      rd_data[b] = bank_q[b][rd_addr];
    end
  end

endmodule : qbsp_mem

// file: logic/qbsp_port.sv
`timescale 1ns/1ns
module qbsp_port
  import qbsp_pkg::*;
#(
  parameter int unsigned LANES      = QBSP_LANES_WIDE,
  parameter int unsigned AW         = (LANES == QBSP_LANES_WIDE) ? QBSP_AW_WIDE
                                                                 : QBSP_AW_NARROW,
  parameter int unsigned FIFO_DEPTH = QBSP_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                            clk,
  input  wire logic                            arst_n,
  // Write port
  input  wire logic                            write_port_select_n,
  input  wire logic [LANES-1:0]                byte_lane_write_enable_n,
  input  wire logic [QBSP_LANE_W*LANES-1:0]    write_data,
  // Shared address and read port select
  input  wire logic [AW-1:0]                   address,
  input  wire logic                            read_port_select_n,
  // Read port
  output logic [QBSP_LANE_W*LANES-1:0]         read_data,
  output logic                                 read_data_oe_n,
  output logic                                 output_valid_flag,
  // Echo strobes
  output logic                                 echo_strobe,
  output logic                                 echo_strobe_n
);

  localparam int unsigned W = QBSP_LANE_W * LANES;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic             wps_n;
    logic             rps_n;
    logic [LANES-1:0] ble_n;
    logic [W-1:0]     wd;
    logic [AW-1:0]    addr;
  } qbsp_pin_s;

  typedef logic [QBSP_BEATS-1:0][W-1:0]     qbsp_line_t;
  typedef logic [QBSP_BEATS-1:0][LANES-1:0] qbsp_mask_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    qbsp_mask_t    mask;
    qbsp_line_t    data;
  } qbsp_wline_s;

  typedef struct packed {
    qbsp_pin_s     sy1;
    qbsp_pin_s     sy2;
    logic          main;
    qbsp_wr_e      wr_st;
    logic [1:0]    wr_beat;
    logic [AW-1:0] wl_addr;
    qbsp_mask_t    wl_mask;
    qbsp_line_t    wl_data;
    logic          rd_block;
    logic          rd_pend;
    logic [1:0]    rd_wait;
    logic [AW-1:0] rd_addr;
    logic [2:0]    ob_cnt;
    qbsp_line_t    ob_line;
    logic [W-1:0]  q_data;
    logic          q_oe_n;
    logic          q_vld;
    logic          echo;
    logic          echo_n;
  } qbsp_state_s;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  qbsp_state_s s;
  qbsp_state_s n;
  qbsp_pin_s   pin_in;
  qbsp_wline_s push_line;
  qbsp_wline_s drain_line;
  qbsp_line_t  mem_line;
  logic        fifo_push;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        wr_acc;
  logic        rd_acc;
  logic        beat_cap;

  // Replaces the lanes flagged in take, keeps the rest
  function automatic logic [W-1:0] lane_merge(input logic [W-1:0]     old_w,
                                              input logic [W-1:0]     new_w,
                                              input logic [LANES-1:0] take);
    logic [W-1:0] res;
    res = old_w;
    for (int l = 0; l < LANES; l++) begin
      if (take[l]) begin
        res[l*QBSP_LANE_W +: QBSP_LANE_W] = new_w[l*QBSP_LANE_W +: QBSP_LANE_W];
      end
    end
    return res;
  endfunction : lane_merge

  assign pin_in = '{wps_n: write_port_select_n, rps_n: read_port_select_n,
                    ble_n: byte_lane_write_enable_n, wd: write_data, addr: address};

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    n         = s;
    fifo_push = 1'b0;
    push_line = '0;
    beat_cap  = 1'b0;
    // Pins cross into the core through two stages; only stage two is used
    n.sy1     = pin_in;
    n.sy2     = s.sy1;
    // Strobe phase: main and complementary halves alternate each cycle
    n.main    = ~s.main;
    n.echo    = ~s.main;
    n.echo_n  = s.main;

    // Write beats, one per half cycle, lanes merged by their enables
    if (s.wr_st == QBSP_WR_BURST) begin
      beat_cap = 1'b1;
      n.wl_data[s.wr_beat] = lane_merge(s.wl_data[s.wr_beat], s.sy2.wd,
                                        ~s.sy2.ble_n);
      n.wl_mask[s.wr_beat] = s.wl_mask[s.wr_beat] | ~s.sy2.ble_n;
      n.wr_beat = s.wr_beat + 2'h1;
      if (s.wr_beat == QBSP_LAST_BEAT) begin
        fifo_push = 1'b1;
        push_line = '{addr: s.wl_addr, mask: n.wl_mask, data: n.wl_data};
        n.wr_st   = QBSP_WR_IDLE;
      end
    end

    // A new write may overlap only the last beat of the previous one
    wr_acc = s.main && !s.sy2.wps_n && fifo_in_ready &&
             (s.wr_st == QBSP_WR_IDLE || s.wr_beat == QBSP_LAST_BEAT);
    if (wr_acc) begin
      n.wr_st   = QBSP_WR_BURST;
      n.wr_beat = 2'h0;
      n.wl_addr = s.sy2.addr;
      n.wl_mask = '0;
    end

    // Read output stage: launch one beat per half cycle
    if (s.ob_cnt != 3'h0) begin
      n.q_data = s.ob_line[2'(QBSP_BURST_LEN - s.ob_cnt)];
      n.q_vld  = 1'b1;
      n.q_oe_n = 1'b0;
      n.ob_cnt = s.ob_cnt - 3'h1;
    end else begin
      n.q_vld = 1'b0;
      // Release the bus only where the next edge is a main one
      if (!s.main) begin
        n.q_oe_n = 1'b1;
      end
    end

    // Read fetch: whole line, overlaid with the open write line
    if (s.rd_pend) begin
      if (s.rd_wait == 2'h0) begin
        for (int b = 0; b < QBSP_BEATS; b++) begin
          n.ob_line[b] = (s.wl_addr == s.rd_addr)
                         ? lane_merge(mem_line[b], s.wl_data[b], s.wl_mask[b])
                         : mem_line[b];
        end
        n.ob_cnt  = QBSP_BURST_LEN;
        n.rd_pend = 1'b0;
      end else begin
        n.rd_wait = s.rd_wait - 2'h1;
      end
    end

    // A read command on the main edge inside a burst window is refused
    rd_acc = s.main && !s.sy2.rps_n && !s.rd_block;
    if (s.main) begin
      n.rd_block = rd_acc;
    end
    if (rd_acc) begin
      n.rd_pend = 1'b1;
      n.rd_wait = QBSP_RD_WAIT_INIT;
      n.rd_addr = s.sy2.addr;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s        <= '0;
      s.sy1    <= '1;
      s.sy2    <= '1;
      s.q_oe_n <= 1'b1;
      s.echo_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------------
  // Write line buffer and array
  // ----------------------------------------------------------------------
  // Lines commit only on main halves; the buffer absorbs the rate mismatch
  qbsp_fifo #(
    .WIDTH ($bits(qbsp_wline_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_wbuf (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (push_line),
    .out_valid (fifo_out_valid),
    .out_ready (s.main),
    .out_data  (drain_line)
  );

  qbsp_mem #(
    .LANES (LANES),
    .AW    (AW)
  ) u_array (
    .clk     (clk),
    .wr_en   (fifo_out_valid && s.main),
    .wr_addr (drain_line.addr),
    .wr_mask (drain_line.mask),
    .wr_data (drain_line.data),
    .rd_addr (s.rd_addr),
    .rd_data (mem_line)
  );

  assign read_data         = s.q_data;
  assign read_data_oe_n    = s.q_oe_n;
  assign output_valid_flag = s.q_vld;
  assign echo_strobe       = s.echo;
  assign echo_strobe_n     = s.echo_n;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  burst_four_beats_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    rd_acc |-> ##4 output_valid_flag [*4] ##1 (!output_valid_flag || $past(rd_acc, 4)))
    else $error("read burst did not give four beats after four cycles");

  burst_not_cut_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (rd_acc ##1 s.sy2.rps_n) |-> ##6 output_valid_flag)
    else $error("read burst cut short after deselect");

  start_main_only_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (rd_acc || wr_acc) |-> (s.main && echo_strobe))
    else $error("access started on a complementary edge");

  write_start_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (s.main && !s.sy2.wps_n && s.wr_st == QBSP_WR_IDLE && fifo_in_ready)
    |=> (s.wr_st == QBSP_WR_BURST && s.wr_beat == 2'h0))
    else $error("write select low did not start a write");

  write_four_beats_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    wr_acc |-> ##1 beat_cap [*4] ##0 fifo_push)
    else $error("write burst did not capture four beats");

  deselect_ignored_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (s.main && s.sy2.wps_n && s.wr_st == QBSP_WR_IDLE) |=> $stable(s.wl_addr))
    else $error("deselected write port took an address");

  masked_lane_kept_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    (wr_acc ##1 s.sy2.ble_n[0]) |=> !s.wl_mask[0][0])
    else $error("disabled lane was marked for writing");

  valid_drives_bus_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    output_valid_flag |-> !read_data_oe_n)
    else $error("valid beat while outputs float");

  float_after_burst_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    ($fell(output_valid_flag) && !rd_acc && !s.rd_pend) |-> read_data_oe_n)
    else $error("outputs still driven after burst end");

  valid_edge_aligned_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    $changed(output_valid_flag) |-> echo_strobe)
    else $error("valid flag changed off a main echo edge");

  echo_free_run_a: assert property (
    @(posedge clk) disable iff (!arst_n)
    $past(arst_n) |-> (echo_strobe != $past(echo_strobe)) && (echo_strobe_n == !echo_strobe))
    else $error("echo strobes not toggling in step");

endmodule : qbsp_port

// file: test/qbsp_ctrl_model.sv
`timescale 1ns/1ns
module qbsp_ctrl_model
  import qbsp_pkg::*;
#(
  parameter int unsigned LANES = QBSP_LANES_WIDE,
  parameter int unsigned AW    = QBSP_AW_WIDE
) (
  // Clock and phase reference
  input  wire logic                     clk,
  input  wire logic                     echo_strobe,
  // Write port
  output logic                          write_port_select_n,
  output logic [LANES-1:0]              byte_lane_write_enable_n,
  output logic [QBSP_LANE_W*LANES-1:0]  write_data,
  // Shared address and read select
  output logic [AW-1:0]                 address,
  output logic                          read_port_select_n
);
  localparam int unsigned W = QBSP_LANE_W * LANES;

  initial begin
    write_port_select_n      = 1'b1;
    byte_lane_write_enable_n = '1;
    write_data               = '0;
    address                  = '0;
    read_port_select_n       = 1'b1;
  end

  // Commands only in main halves; off-phase only when a test asks for it
  task automatic wait_phase(input logic ph);
    do @(negedge clk); while (echo_strobe !== ph);
  endtask : wait_phase

  task automatic write_line(input logic [AW-1:0] a, input logic [3:0][W-1:0] d,
                            input logic [3:0][LANES-1:0] m, input int unsigned gap);
    repeat (gap) @(negedge clk);
    wait_phase(1'b1);
    write_port_select_n = 1'b0;
    address = a;
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      write_port_select_n = 1'b1;
      address = ~a;
      write_data = d[k];
      byte_lane_write_enable_n = m[k];
    end
    @(negedge clk);
    // Released lines show the inverse of their last value
    write_data = ~write_data;
    byte_lane_write_enable_n = ~byte_lane_write_enable_n;
  endtask : write_line

  task automatic read_line(input logic [AW-1:0] a, input int unsigned gap, input logic off);
    repeat (gap) @(negedge clk);
    wait_phase(!off);
    read_port_select_n = 1'b0;
    address = a;
    @(negedge clk);
    read_port_select_n = 1'b1;
    address = ~a;
  endtask : read_line

  // Write port deselected while data keeps moving, with all lanes enabled and the address held at a
  task automatic idle_noise(input logic [AW-1:0] a, input int unsigned n);
    repeat (n) begin
      @(negedge clk);
      address = a;
      write_data = W'({$urandom, $urandom});
      byte_lane_write_enable_n = '0;
    end
  endtask : idle_noise
endmodule : qbsp_ctrl_model

// file: test/tb_quad_burst_sram_port.sv
`timescale 1ns/1ns
module tb_quad_burst_sram_port
  import qbsp_pkg::*;
;
  localparam int unsigned WATCHDOG_CYC = 4000;
  logic        clk;
  logic        arst_n;
  logic        write_port_select_n;
  logic [3:0]  byte_lane_write_enable_n;
  logic [35:0] write_data;
  logic [18:0] address;
  logic        read_port_select_n;
  logic [35:0] read_data;
  logic        read_data_oe_n;
  logic        output_valid_flag;
  logic        echo_strobe;
  logic        echo_strobe_n;
  logic        echo_prev;
  int          num_errors;
  int          checks_done;
  int          cyc;
  int          last_rd;
  int          due_q[$];
  logic [35:0] exp_q[$];
  logic [35:0] mem[bit [20:0]];
  logic [18:0] a[6];

  qbsp_port dut (.clk(clk), .arst_n(arst_n), .write_port_select_n(write_port_select_n),
    .byte_lane_write_enable_n(byte_lane_write_enable_n), .write_data(write_data),
    .address(address), .read_port_select_n(read_port_select_n), .read_data(read_data),
    .read_data_oe_n(read_data_oe_n), .output_valid_flag(output_valid_flag),
    .echo_strobe(echo_strobe), .echo_strobe_n(echo_strobe_n));

  qbsp_ctrl_model ctrl (.clk(clk), .echo_strobe(echo_strobe),
    .write_port_select_n(write_port_select_n),
    .byte_lane_write_enable_n(byte_lane_write_enable_n), .write_data(write_data),
    .address(address), .read_port_select_n(read_port_select_n));

  // --------------------------------
  // Checking and verdict
  // --------------------------------
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL t=%0t cycle %0d: saw %h expected %h", $time, cyc, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  // --------------------------------
  // Reference model
  // --------------------------------
  // A read taken at a main edge yields four beats from the sixth cycle on;
  // one at the very next main edge is dropped
  always @(posedge clk) begin
    if (arst_n && read_port_select_n === 1'b0 && echo_strobe === 1'b1
        && cyc != last_rd + 2) begin
      last_rd = cyc;
      for (int k = 0; k < 4; k++) begin
        due_q.push_back(cyc + 6 + k);
        exp_q.push_back(mem[{address, 2'(k)}]);
      end
    end
    cyc++;
  end

  always @(negedge clk) begin
    if (arst_n) begin
      check(echo_strobe_n, !echo_strobe);
      check(echo_strobe, !echo_prev);
      if (due_q.size() > 0 && due_q[0] == cyc) begin
        check(output_valid_flag, 1'b1);
        check(read_data, exp_q[0]);
        check(read_data_oe_n, 1'b0);
        void'(due_q.pop_front());
        void'(exp_q.pop_front());
      end else begin
        check(output_valid_flag, 1'b0);
        check(read_data_oe_n, 1'b1);
      end
    end
    echo_prev = echo_strobe;
  end

  task automatic wr(input logic [18:0] ad, input logic [3:0][3:0] m, input int unsigned gap);
    logic [3:0][35:0] d;
    for (int k = 0; k < 4; k++) begin
      d[k] = 36'({$urandom, $urandom});
      for (int l = 0; l < 4; l++)
        if (!m[k][l]) mem[{ad, 2'(k)}][9*l +: 9] = d[k][9*l +: 9];
    end
    ctrl.write_line(ad, d, m, gap);
  endtask : wr

  // --------------------------------
  // Clock, reset and scenarios
  // --------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (WATCHDOG_CYC) @(posedge clk);
    num_errors++;
    end_of_test();
  end

  initial begin
    arst_n = 1'b0;
    cyc = 0;
    last_rd = -10;
    echo_prev = 1'b0;
    num_errors = 0;
    checks_done = 0;
    void'($urandom(32'h87EF1921));
    repeat (4) @(negedge clk);
    arst_n <= 1'b1;
    // Full line then read back, then a lane-masked merge onto it
    wr(19'h00010, '0, 0);
    ctrl.read_line(19'h00010, 0, 1'b0);
    wr(19'h00010, 16'($urandom), 3);
    ctrl.read_line(19'h00010, 0, 1'b0);
    // Random lines with random spacing; the last one masks a different lane per beat
    for (int i = 0; i < 6; i++) begin
      a[i] = 19'($urandom);
      wr(a[i], '0, $urandom % 3);
    end
    wr(a[5], 16'h8421, 0);
    // Reads on every other main edge: beats run without a gap
    for (int i = 0; i < 6; i++) ctrl.read_line(a[i], 1, 1'b0);
    // A read at the next main edge is dropped; an off-phase one never starts
    ctrl.read_line(a[1], 0, 1'b0);
    ctrl.read_line(a[2], 0, 1'b0);
    ctrl.read_line(a[3], 4, 1'b1);
    // Deselected write port ignores moving data with all lanes enabled at a held address
    ctrl.idle_noise(a[0], 12);
    ctrl.read_line(a[0], 2, 1'b0);
    repeat (20) @(negedge clk);
    check(36'(due_q.size()), 36'h0);
    end_of_test();
  end
endmodule : tb_quad_burst_sram_port
